// file: inc/encoder_output_control_pkg.sv
// Types shared by the encoder output control bank
package encoder_output_control_pkg;

  // One YUV sample, eight bits per component
  typedef struct packed {
    logic [7:0] u;
    logic [7:0] v;
    logic [7:0] y;
  } pixel_t;

  // The three encoder DAC codes
  typedef struct packed {
    logic [9:0] cvbs;
    logic [9:0] luma;
    logic [9:0] chroma;
  } enc_dac_t;

  // The three RGB DAC codes
  typedef struct packed {
    logic [8:0] red;
    logic [8:0] green;
    logic [8:0] blue;
  } rgb_dac_t;

  // Register write and read request from the serial control front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] sub_addr;
    logic [7:0] data;
  } reg_req_t;

endpackage

// file: inc/encoder_output_control_regs.svh
// Subaddresses, field positions and reset values of the encoder output control bank
`ifndef ENCODER_OUTPUT_CONTROL_REGS_SVH
`define ENCODER_OUTPUT_CONTROL_REGS_SVH

// ----------------------------------------------------------------
// Subaddresses
// ----------------------------------------------------------------
`define COPY_GEN_CONTROL_OFS 8'h2C
`define DAC_ROUTING_DRIVE_OFS 8'h2D
`define RGB_LUMA_GAIN_OFS 8'h38
`define RGB_CHROMA_GAIN_OFS 8'h39
`define SOURCE_SELECT_OFS 8'h3A
`define KEY_ONE_LOWER_U_OFS 8'h42
`define KEY_ONE_LOWER_V_OFS 8'h43
`define KEY_ONE_LOWER_Y_OFS 8'h44
`define KEY_ONE_UPPER_U_OFS 8'h48
`define KEY_ONE_UPPER_V_OFS 8'h49
`define KEY_ONE_UPPER_Y_OFS 8'h4A
`define FIRST_FADE_OFS 8'h4E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define COPY_OUTPUT_ENABLE_BIT 7
`define COPY_CODE_HIGH_MSB 3
`define Y_DAC_COMPOSITE_BIT 7
`define C_DAC_COMPOSITE_BIT 6
`define DAC_DRIVE_MSB 5
`define GAIN_MSB 4
`define TEST_BAR_BIT 7
`define EMBEDDED_TRIGGER_BIT 4
`define MATRIX_BYPASS_BIT 3
`define COMPOSITE_SYNC_BIT 2
`define MPEG_BINARY_BIT 1
`define VIDEO_BINARY_BIT 0
`define FADE_MSB 5

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define COPY_GEN_CONTROL_RST 8'h00
`define DAC_ROUTING_DRIVE_RST 8'h3F
`define RGB_GAIN_RST 5'h00
`define SOURCE_SELECT_RST 8'h03
`define SOURCE_SELECT_MASK 8'h9F
`define COPY_GEN_CONTROL_MASK 8'h8F
`define KEY_LIMIT_RST 8'h80
`define FIRST_FADE_RST 6'h3F
`define FADE_FULL 7'h40

`endif

// file: rtl/encoder_output_control_regs.sv
// Output control registers, DAC routing and key colour one fader of the video encoder
// Functional notes
// - Low nibble of copy control holds copy code bits nineteen to sixteen.
// - Routing bit 7 feeds Y DAC with luma (0) or composite (1).
// - Routing bit 6 feeds C DAC with chroma (0) or composite (1).
// - Routing bits 5..0 drive composite,Y,C,R,G,B DACs; 0 is high impedance.
// - Five-bit signed luma gain for RGB path, nominal minus six.
// - Five-bit signed colour-difference gain for RGB path, nominal minus six.
// - Source bit 7 encodes port data (0) or fixed colour bars (1).
// - Source bit 4 takes triggers from sync pins (0) or embedded codes (1).
// - Source bit 3 enables RGB dematrix (0) or bypasses it (1).
// - Source bit 2 feeds composite DAC with video (0) or composite sync (1).
// - Source bit 1 reads MPEG fader input as twos complement or binary.
// - Source bit 0 reads video fader input as twos complement or binary.
// - Six key one limit bytes, lower then upper U,V,Y, reset midscale.
// - On key hit output fade times video plus rest times MPEG.
// - Six-bit fade factor, zero all MPEG, maximum all video, reset maximum.
// - Copy control bit 7 enables copy generation data output.
`timescale 1ns/1ps
`include "encoder_output_control_regs.svh"

module encoder_output_control_regs
  import encoder_output_control_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port from the serial control front end
  input wire reg_req_t req,
  output logic [7:0] rd_data_q,
  // Encoder settings
  output logic copy_output_enable_q,
  output logic [3:0] copy_code_high_q,
  output logic [4:0] rgb_luma_gain_field_q,
  output logic [4:0] rgb_colordiff_gain_field_q,
  output logic test_bar_select_q,
  output logic rgb_matrix_bypass_q,
  // Trigger sources
  input wire logic horizontal_sync_pin,
  input wire logic vertical_sync_pin,
  input wire logic embedded_h_trig,
  input wire logic embedded_v_trig,
  output logic h_trig_q,
  output logic v_trig_q,
  // DAC sources and outputs
  input wire enc_dac_t enc_in,
  input wire logic adv_composite_sync_select,
  input wire rgb_dac_t rgb_in,
  output enc_dac_t enc_dac_q,
  output rgb_dac_t rgb_dac_q,
  output logic [5:0] dac_oe_b_q,
  // Fader ports
  input wire logic pix_valid,
  input wire pixel_t mpeg_pix,
  input wire pixel_t video_pix,
  output pixel_t fade_pix_q,
  output logic fade_valid_q,
  output logic key_one_hit_q
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Assert at once, release after two clean edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] copy_q, copy_d;
  logic [7:0] route_q, route_d;
  logic [4:0] luma_gain_q, luma_gain_d;
  logic [4:0] chroma_gain_q, chroma_gain_d;
  logic [7:0] src_q, src_d;
  logic [5:0] fade_q, fade_d;
  logic [7:0] key_q [0:5];
  logic [7:0] key_d [0:5];
  logic [7:0] rd_data_d;

  // Writes; reserved bits are masked so they always read back as zero
  always_comb
  begin
    copy_d = copy_q;
    route_d = route_q;
    luma_gain_d = luma_gain_q;
    chroma_gain_d = chroma_gain_q;
    src_d = src_q;
    fade_d = fade_q;
    if (req.wr)
    begin
      unique case (req.sub_addr)
        `COPY_GEN_CONTROL_OFS: copy_d = req.data & `COPY_GEN_CONTROL_MASK;
        `DAC_ROUTING_DRIVE_OFS: route_d = req.data;
        `RGB_LUMA_GAIN_OFS: luma_gain_d = req.data[`GAIN_MSB:0];
        `RGB_CHROMA_GAIN_OFS: chroma_gain_d = req.data[`GAIN_MSB:0];
        `SOURCE_SELECT_OFS: src_d = req.data & `SOURCE_SELECT_MASK;
        `FIRST_FADE_OFS: fade_d = req.data[`FADE_MSB:0];
        default: ;
      endcase
    end
  end

  // Key limit bytes: lower U,V,Y then upper U,V,Y
  genvar k;
  generate
    for (k = 0; k < 6; k++)
    begin : g_key
      localparam logic [7:0] KEY_OFS = (k < 3) ? (`KEY_ONE_LOWER_U_OFS + 8'(k))
                                               : (`KEY_ONE_UPPER_U_OFS + 8'(k - 3));
      always_comb
      begin
        key_d[k] = key_q[k];
        if (req.wr && req.sub_addr == KEY_OFS)
          key_d[k] = req.data;
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          key_q[k] <= `KEY_LIMIT_RST;
        else if (ce)
          key_q[k] <= key_d[k];
      end
    end
  endgenerate

  // Read-back; unmapped subaddresses answer zero
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (req.rd)
    begin
      unique case (req.sub_addr)
        `COPY_GEN_CONTROL_OFS: rd_data_d = copy_q;
        `DAC_ROUTING_DRIVE_OFS: rd_data_d = route_q;
        `RGB_LUMA_GAIN_OFS: rd_data_d = {3'h0, luma_gain_q};
        `RGB_CHROMA_GAIN_OFS: rd_data_d = {3'h0, chroma_gain_q};
        `SOURCE_SELECT_OFS: rd_data_d = src_q;
        `KEY_ONE_LOWER_U_OFS: rd_data_d = key_q[0];
        `KEY_ONE_LOWER_V_OFS: rd_data_d = key_q[1];
        `KEY_ONE_LOWER_Y_OFS: rd_data_d = key_q[2];
        `KEY_ONE_UPPER_U_OFS: rd_data_d = key_q[3];
        `KEY_ONE_UPPER_V_OFS: rd_data_d = key_q[4];
        `KEY_ONE_UPPER_Y_OFS: rd_data_d = key_q[5];
        `FIRST_FADE_OFS: rd_data_d = {2'h0, fade_q};
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copy_q <= `COPY_GEN_CONTROL_RST;
      route_q <= `DAC_ROUTING_DRIVE_RST;
      luma_gain_q <= `RGB_GAIN_RST;
      chroma_gain_q <= `RGB_GAIN_RST;
      src_q <= `SOURCE_SELECT_RST;
      fade_q <= `FIRST_FADE_RST;
      rd_data_q <= 8'h00;
    end
    else if (ce)
    begin
      copy_q <= copy_d;
      route_q <= route_d;
      luma_gain_q <= luma_gain_d;
      chroma_gain_q <= chroma_gain_d;
      src_q <= src_d;
      fade_q <= fade_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Setting outputs
  // ----------------------------------------------------------------
  // Registered copies so every setting leaves the block from a flip-flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copy_output_enable_q <= 1'b0;
      copy_code_high_q <= 4'h0;
      rgb_luma_gain_field_q <= `RGB_GAIN_RST;
      rgb_colordiff_gain_field_q <= `RGB_GAIN_RST;
      test_bar_select_q <= 1'b0;
      rgb_matrix_bypass_q <= 1'b0;
    end
    else if (ce)
    begin
      copy_output_enable_q <= copy_d[`COPY_OUTPUT_ENABLE_BIT];
      copy_code_high_q <= copy_d[`COPY_CODE_HIGH_MSB:0];
      rgb_luma_gain_field_q <= luma_gain_d;
      rgb_colordiff_gain_field_q <= chroma_gain_d;
      test_bar_select_q <= src_d[`TEST_BAR_BIT];
      rgb_matrix_bypass_q <= src_d[`MATRIX_BYPASS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  logic [1:0] hsync_meta_q, vsync_meta_q;
  logic h_trig_d, v_trig_d;

  // Sync pins are asynchronous; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hsync_meta_q <= 2'b00;
      vsync_meta_q <= 2'b00;
    end
    else if (ce)
    begin
      hsync_meta_q <= {hsync_meta_q[0], horizontal_sync_pin};
      vsync_meta_q <= {vsync_meta_q[0], vertical_sync_pin};
    end
  end

  // Pins or embedded timing codes
  always_comb
  begin
    h_trig_d = src_q[`EMBEDDED_TRIGGER_BIT] ? embedded_h_trig : hsync_meta_q[1];
    v_trig_d = src_q[`EMBEDDED_TRIGGER_BIT] ? embedded_v_trig : vsync_meta_q[1];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_trig_q <= 1'b0;
      v_trig_q <= 1'b0;
    end
    else if (ce)
    begin
      h_trig_q <= h_trig_d;
      v_trig_q <= v_trig_d;
    end
  end

  // ----------------------------------------------------------------
  // DAC routing and drive
  // ----------------------------------------------------------------
  enc_dac_t enc_dac_d;
  logic [5:0] dac_oe_b_d;

  // Source muxes; composite sync is a level mapped to full scale
  always_comb
  begin
    enc_dac_d.cvbs = src_q[`COMPOSITE_SYNC_BIT] ? {10{adv_composite_sync_select}} : enc_in.cvbs;
    enc_dac_d.luma = route_q[`Y_DAC_COMPOSITE_BIT] ? enc_in.cvbs : enc_in.luma;
    enc_dac_d.chroma = route_q[`C_DAC_COMPOSITE_BIT] ? enc_in.cvbs : enc_in.chroma;
    dac_oe_b_d = ~route_q[`DAC_DRIVE_MSB:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enc_dac_q <= '0;
      rgb_dac_q <= '0;
      dac_oe_b_q <= 6'h3F;
    end
    else if (ce)
    begin
      enc_dac_q <= enc_dac_d;
      rgb_dac_q <= rgb_in;
      dac_oe_b_q <= dac_oe_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Key colour one fader
  // ----------------------------------------------------------------
  pixel_t mpeg_ob, video_ob, fade_pix_d;
  logic hit;
  logic [6:0] weight, weight_inv;
  logic fade_valid_d, key_one_hit_d;

  // Twos complement becomes offset binary by flipping each sign bit
  always_comb
  begin
    mpeg_ob = mpeg_pix;
    video_ob = video_pix;
    if (!src_q[`MPEG_BINARY_BIT])
    begin
      mpeg_ob.u[7] = ~mpeg_pix.u[7];
      mpeg_ob.v[7] = ~mpeg_pix.v[7];
      mpeg_ob.y[7] = ~mpeg_pix.y[7];
    end
    if (!src_q[`VIDEO_BINARY_BIT])
    begin
      video_ob.u[7] = ~video_pix.u[7];
      video_ob.v[7] = ~video_pix.v[7];
      video_ob.y[7] = ~video_pix.y[7];
    end
  end

  // All three components inside their limits; weight stretched to 0..64 so the top code is pure video
  always_comb
  begin
    hit = (mpeg_ob.u >= key_q[0]) && (mpeg_ob.u <= key_q[3]) &&
          (mpeg_ob.v >= key_q[1]) && (mpeg_ob.v <= key_q[4]) &&
          (mpeg_ob.y >= key_q[2]) && (mpeg_ob.y <= key_q[5]);
    weight = {1'b0, fade_q} + {6'h00, fade_q[5]};
    weight_inv = `FADE_FULL - weight;
  end

  // Blend one component; shift by six instead of dividing by 63
  function automatic logic [7:0] blend(input logic [7:0] vid, input logic [7:0] mpg,
                                       input logic [6:0] w, input logic [6:0] wi);
    logic [14:0] acc;
    acc = 15'(w) * 15'(vid) + 15'(wi) * 15'(mpg);
    return acc[13:6];
  endfunction

  // Blended sample on a key hit, MPEG sample passed on otherwise
  always_comb
  begin
    fade_pix_d = fade_pix_q;
    fade_valid_d = pix_valid;
    key_one_hit_d = key_one_hit_q;
    if (pix_valid)
    begin
      key_one_hit_d = hit;
      fade_pix_d = mpeg_ob;
      if (hit)
      begin
        fade_pix_d.u = blend(video_ob.u, mpeg_ob.u, weight, weight_inv);
        fade_pix_d.v = blend(video_ob.v, mpeg_ob.v, weight, weight_inv);
        fade_pix_d.y = blend(video_ob.y, mpeg_ob.y, weight, weight_inv);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fade_pix_q <= '0;
      fade_valid_q <= 1'b0;
      key_one_hit_q <= 1'b0;
    end
    else if (ce)
    begin
      fade_pix_q <= fade_pix_d;
      fade_valid_q <= fade_valid_d;
      key_one_hit_q <= key_one_hit_d;
    end
  end

endmodule // encoder_output_control_regs

// file: tb/encoder_output_control_props.sv
// Port checks for the encoder output control bank
`timescale 1ns/1ps
module encoder_output_control_props
  import encoder_output_control_pkg::*;
(
  // Clock and requests
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire reg_req_t req,
  // Sources
  input wire logic horizontal_sync_pin,
  input wire logic embedded_v_trig,
  input wire enc_dac_t enc_in,
  input wire logic adv_composite_sync_select,
  input wire logic pix_valid,
  // Settings and outputs
  input wire logic copy_output_enable_q,
  input wire logic [3:0] copy_code_high_q,
  input wire logic [4:0] rgb_luma_gain_field_q,
  input wire logic test_bar_select_q,
  input wire logic rgb_matrix_bypass_q,
  input wire logic h_trig_q,
  input wire logic v_trig_q,
  input wire enc_dac_t enc_dac_q,
  input wire logic [5:0] dac_oe_b_q,
  input wire pixel_t fade_pix_q,
  input wire logic key_one_hit_q
);
  // ----------------------------------------------------------------
  // Shadow bytes and checks
  // ----------------------------------------------------------------
  logic [2:0] sync_q;
  logic [7:0] route_q;
  logic [7:0] src_q;
  // One stage longer than the bank's release, to skip its dead cycles
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], 1'b1};
  // Routing shadow
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      route_q <= 8'h3F;
    else if (ce && req.wr && req.sub_addr == 8'h2D)
      route_q <= req.data;
  // Source select shadow
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      src_q <= 8'h03;
    else if (ce && req.wr && req.sub_addr == 8'h3A)
      src_q <= req.data;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!sync_q[2]);
  sequence s_wr(logic [7:0] a);
    ce && req.wr && req.sub_addr == a;
  endsequence
  property p_copy;
    s_wr(8'h2C) |=> copy_output_enable_q == $past(req.data[7]) && copy_code_high_q == $past(req.data[3:0]);
  endproperty
  a_copy: assert property (p_copy) else $error("copy bits wrong");
  property p_gain;
    s_wr(8'h38) |=> rgb_luma_gain_field_q == $past(req.data[4:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("luma gain wrong");
  property p_src;
    s_wr(8'h3A) |=> test_bar_select_q == $past(req.data[7]) && rgb_matrix_bypass_q == $past(req.data[3]);
  endproperty
  a_src: assert property (p_src) else $error("source bits wrong");
  property p_oe;
    ce |=> dac_oe_b_q == ~$past(route_q[5:0]);
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable wrong");
  property p_ydac;
    ce |=> enc_dac_q.luma == ($past(route_q[7]) ? $past(enc_in.cvbs) : $past(enc_in.luma));
  endproperty
  a_ydac: assert property (p_ydac) else $error("Y DAC source wrong");
  property p_cdac;
    ce |=> enc_dac_q.chroma == ($past(route_q[6]) ? $past(enc_in.cvbs) : $past(enc_in.chroma));
  endproperty
  a_cdac: assert property (p_cdac) else $error("C DAC source wrong");
  property p_cvbs;
    ce |=> enc_dac_q.cvbs == ($past(src_q[2]) ? {10{$past(adv_composite_sync_select)}} : $past(enc_in.cvbs));
  endproperty
  a_cvbs: assert property (p_cvbs) else $error("composite DAC source wrong");
  sequence s_pin_run;
    ce [*2] ##1 (ce && !src_q[4]);
  endsequence
  property p_hpin;
    s_pin_run |=> h_trig_q == $past(horizontal_sync_pin, 3);
  endproperty
  a_hpin: assert property (p_hpin) else $error("pin trigger wrong");
  property p_vemb;
    ce && src_q[4] |=> v_trig_q == $past(embedded_v_trig);
  endproperty
  a_vemb: assert property (p_vemb) else $error("embedded trigger wrong");
  property p_hold;
    ce && !pix_valid |=> $stable(fade_pix_q) && $stable(key_one_hit_q);
  endproperty
  a_hold: assert property (p_hold) else $error("fader output moved");
endmodule // encoder_output_control_props

bind encoder_output_control_regs encoder_output_control_props u_props (.clk, .rst_b, .ce, .req,
  .horizontal_sync_pin, .embedded_v_trig, .enc_in, .adv_composite_sync_select, .pix_valid, .copy_output_enable_q,
  .copy_code_high_q, .rgb_luma_gain_field_q, .test_bar_select_q, .rgb_matrix_bypass_q, .h_trig_q,
  .v_trig_q, .enc_dac_q, .dac_oe_b_q, .fade_pix_q, .key_one_hit_q);

// file: tb/host_model.sv
// Register host model that writes and reads the bank
`timescale 1ns/1ps
module host_model
  import encoder_output_control_pkg::*;
(
  // Clock and read return
  input wire logic clk,
  input wire logic [7:0] rd_data_q,
  // Request toward the bank
  output reg_req_t req
);
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  initial req = '0;
  // One-cycle strobe from a falling edge so the bank samples it settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = d;
    if (a == 8'h38 || a == 8'h39)
      m[7:5] = 3'h0;
    if (a == 8'h3A)
      m[6:5] = 2'h0;
    @(negedge clk);
    req <= {1'b1, 1'b0, a, m};
    @(negedge clk);
    req <= '0;
  endtask
  // Read data is registered, so it is settled one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req <= '0;
    d = rd_data_q;
  endtask
endmodule // host_model

// file: tb/tb_top.sv
// Self-checking bench for the encoder output control bank
`timescale 1ns/1ps
module tb_top
  import encoder_output_control_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, rows and tasks
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] b;} row_t;
  // Address, reset value, written value, read-back value
  row_t rows [13] = '{32'h2C008F8F, 32'h2D3FC0C0, 32'h38001A1A, 32'h39001A1A, 32'h3A039F9F,
    32'h42801010, 32'h43802020, 32'h44803030, 32'h48804040, 32'h49805050, 32'h4A806060,
    32'h4E3F2525, 32'h60005500};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic horizontal_sync_pin = 1'b0, vertical_sync_pin = 1'b0, adv_composite_sync_select = 1'b1, pix_valid = 1'b0;
  logic embedded_h_trig = 1'b0, embedded_v_trig = 1'b0;
  logic copy_output_enable_q, test_bar_select_q, rgb_matrix_bypass_q, h_trig_q, v_trig_q;
  logic fade_valid_q, key_one_hit_q;
  logic [3:0] copy_code_high_q;
  logic [4:0] rgb_luma_gain_field_q, rgb_colordiff_gain_field_q;
  logic [5:0] dac_oe_b_q;
  logic [7:0] rd_data_q, d;
  enc_dac_t enc_in = {10'h2AA, 10'h155, 10'h0F0};
  enc_dac_t enc_dac_q;
  rgb_dac_t rgb_in = {9'h1AA, 9'h055, 9'h0F0};
  rgb_dac_t rgb_dac_q;
  pixel_t mpeg_pix = '0, video_pix = '0, fade_pix_q;
  pixel_t lo = 24'h102030, hi = 24'h405060, vid = 24'hC8379A;
  reg_req_t req;
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  encoder_output_control_regs dut (.clk, .rst_b, .ce, .req, .rd_data_q, .copy_output_enable_q,
    .copy_code_high_q, .rgb_luma_gain_field_q, .rgb_colordiff_gain_field_q, .test_bar_select_q,
    .rgb_matrix_bypass_q, .horizontal_sync_pin, .vertical_sync_pin, .embedded_h_trig, .embedded_v_trig,
    .h_trig_q, .v_trig_q, .enc_in, .adv_composite_sync_select, .rgb_in, .enc_dac_q, .rgb_dac_q, .dac_oe_b_q,
    .pix_valid, .mpeg_pix, .video_pix, .fade_pix_q, .fade_valid_q, .key_one_hit_q);
  host_model h (.clk, .rd_data_q, .req);

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [29:0] got, input logic [29:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %0t output %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Blend weight reaches 64 at full scale so both ends are exact
  function automatic logic [7:0] mix(input logic [5:0] f, input logic [7:0] m, input logic [7:0] v);
    logic [15:0] w;
    w = 16'(f) + 16'(f[5]);
    return 8'((w * v + (16'h40 - w) * m) >> 6);
  endfunction
  function automatic pixel_t bl(input logic [5:0] f, input pixel_t m, input pixel_t v);
    return {mix(f, m.u, v.u), mix(f, m.v, v.v), mix(f, m.y, v.y)};
  endfunction
  task automatic dac_chk(input logic [7:0] rt, input logic [7:0] sr);
    h.wr(8'h2D, rt);
    h.wr(8'h3A, sr);
    repeat (2) @(negedge clk);
    chk_out(30'(enc_dac_q.luma), 30'(rt[7] ? enc_in.cvbs : enc_in.luma));
    chk_out(30'(enc_dac_q.chroma), 30'(rt[6] ? enc_in.cvbs : enc_in.chroma));
    chk_out(30'(enc_dac_q.cvbs), 30'(sr[2] ? {10{adv_composite_sync_select}} : enc_in.cvbs));
    chk_out(30'(dac_oe_b_q), 30'(rt[5:0] ^ 6'h3F));
    chk_out(30'(rgb_dac_q), 30'(rgb_in));
  endtask
  task automatic pix(input pixel_t m, input pixel_t v, input logic hit, input pixel_t exp);
    @(negedge clk);
    mpeg_pix = m;
    video_pix = v;
    pix_valid = 1'b1;
    @(negedge clk);
    pix_valid = 1'b0;
    chk_out(30'(fade_valid_q), 30'h1);
    chk_out(30'(key_one_hit_q), 30'(hit));
    chk_out(30'(fade_pix_q), 30'(exp));
  endtask

  // Watchdog against a hung sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk_out(30'(dac_oe_b_q), 30'h0);
    foreach (rows[i])
    begin
      h.rd(rows[i].a, d);
      chk_reg(d, rows[i].r);
      h.wr(rows[i].a, rows[i].w);
      h.rd(rows[i].a, d);
      chk_reg(d, rows[i].b);
    end
    chk_out(30'({copy_output_enable_q, copy_code_high_q}), 30'h1F);
    chk_out(30'({rgb_luma_gain_field_q, rgb_colordiff_gain_field_q}), 30'h35A);
    chk_out(30'({test_bar_select_q, rgb_matrix_bypass_q}), 30'h3);
    // Frozen clock enable must drop the write
    ce = 1'b0;
    h.wr(8'h2C, 8'h00);
    ce = 1'b1;
    h.rd(8'h2C, d);
    chk_reg(d, 8'h8F);
    dac_chk(8'hC0, 8'h9F);
    embedded_h_trig = 1'b1;
    embedded_v_trig = 1'b1;
    adv_composite_sync_select = 1'b0;
    @(negedge clk);
    chk_out(30'({h_trig_q, v_trig_q}), 30'h3);
    dac_chk(8'h3F, 8'h03);
    embedded_h_trig = 1'b0;
    embedded_v_trig = 1'b0;
    horizontal_sync_pin = 1'b1;
    vertical_sync_pin = 1'b1;
    repeat (3) @(negedge clk);
    chk_out(30'({h_trig_q, v_trig_q}), 30'h3);
    // Key limits at both boundaries and one step outside
    pix(lo, vid, 1'b1, bl(6'h25, lo, vid));
    pix(hi, vid, 1'b1, bl(6'h25, hi, vid));
    pix(24'h415060, vid, 1'b0, 24'h415060);
    pix(24'h40502F, vid, 1'b0, 24'h40502F);
    h.wr(8'h4E, 8'h3F);
    pix(lo, vid, 1'b1, vid);
    h.wr(8'h4E, 8'h00);
    pix(hi, vid, 1'b1, hi);
    h.wr(8'h3A, 8'h01);
    pix(24'h90A0B0, vid, 1'b1, lo);
    h.wr(8'h3A, 8'h02);
    h.wr(8'h4E, 8'h3F);
    pix(lo, vid, 1'b1, vid ^ 24'h808080);
    // Reset in mid-run restores defaults
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    h.rd(8'h3A, d);
    chk_reg(d, 8'h03);
    wrap_up();
  end
endmodule // tb_top
